// >>> ppsc_consts.svh
// How it works
// - share: bypass 1, listed values 6, else 4
// - sync mode puts share inside the loop
// - sync pulse picks the restart reference edge
// - only out-of-loop dividers get realigned
// - entering sync mode does a software sync
// - pin honoured only with sync-ignore cleared
// - pin sync or modulator reset loads seed
// - a seed write adds to the accumulator unless a seed load wins
// - delay is seed*share over denominator*divide
// - zero numerator still lets seed shift phase
`ifndef PPSC_CONSTS_SVH
`define PPSC_CONSTS_SVH

// in-loop shares of the channel divide
`define PPSC_SHARE_BYPASS 3'h1
`define PPSC_SHARE_SIX 3'h6
`define PPSC_SHARE_FOUR 3'h4

// channel divide values that fold six into the loop
`define PPSC_DIV_6 11'h006
`define PPSC_DIV_12 11'h00C
`define PPSC_DIV_48 11'h030
`define PPSC_DIV_72 11'h048
`define PPSC_DIV_96 11'h060
`define PPSC_DIV_384 11'h180
`define PPSC_DIV_768 11'h300

// reset values
`define PPSC_RST_SHARE 3'h1
`define PPSC_RST_COUNT 11'h000

`endif

// >>> ppsc_pkg.sv
`default_nettype none
package ppsc_pkg;
	// sync controller states, one-hot
	typedef enum logic [2:0] {
		PPSC_FREE = 3'h1,
		PPSC_ARMED = 3'h2,
		PPSC_ALIGN = 3'h4
	} ppsc_state_type;
endpackage : ppsc_pkg
`default_nettype wire

// >>> ppsc_phase_sync.sv
`include "ppsc_consts.svh"
`default_nettype none
module ppsc_phase_sync
	import ppsc_pkg::*;
#(
	parameter int ACC_W = 32,
	parameter int REFDIV_W = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic phase_align_mode_en,
	input wire logic sync_ignore,
	input wire logic sync_pin,
	input wire logic modulator_reset_n,
	input wire logic [ACC_W-1:0] modulator_seed,
	input wire logic seed_write,
	input wire logic [ACC_W-1:0] frac_numerator,
	input wire logic [ACC_W-1:0] frac_denominator,
	input wire logic [10:0] output_divide_value,
	input wire logic output_divide_bypass,
	input wire logic [REFDIV_W-1:0] ref_divide_value,
	output logic [2:0] in_loop_divide_share,
	output logic [10:0] outLoopDivide,
	output logic [ACC_W-1:0] fracAccum,
	output logic fracCarry,
	output logic refDivTick,
	output logic chanDivTick,
	output logic syncApplied,
	output logic syncModeActive,
	output logic [ACC_W+2:0] phaseDelayNum,
	output logic [ACC_W+10:0] phaseDelayDen
);

	typedef struct packed {
		ppsc_state_type state;
		logic syncMeta;
		logic syncSafe;
		logic syncPrev;
		logic modePrev;
		logic [2:0] share;
		logic [10:0] outDiv;
		logic [ACC_W-1:0] acc;
		logic carry;
		logic [REFDIV_W-1:0] refCnt;
		logic [10:0] chanCnt;
		logic refTick;
		logic chanTick;
		logic applied;
		logic active;
		logic [ACC_W+2:0] delayNum;
		logic [ACC_W+10:0] delayDen;
	} ppsc_regs_type;

	ppsc_regs_type regs_q;
	ppsc_regs_type regs_d;

	logic [2:0] tableShare;
	logic [10:0] tableOutDiv;
	logic pinEdge;
	logic pinSync;
	logic softSync;
	logic alignNow;
	logic [ACC_W:0] stepSum;
	logic [ACC_W:0] wrapSum;
	logic [ACC_W:0] seedSum;
	logic [ACC_W:0] seedWrap;
	logic [REFDIV_W-1:0] refLast;
	logic [10:0] chanLast;

	// share lookup; the rest of the divide stays outside the loop
	always_comb begin
		case (output_divide_value)
			`PPSC_DIV_6, `PPSC_DIV_12, `PPSC_DIV_48, `PPSC_DIV_72,
			`PPSC_DIV_96, `PPSC_DIV_384, `PPSC_DIV_768: begin
				tableShare = `PPSC_SHARE_SIX;
				tableOutDiv = output_divide_value / 11'h006;
			end
			default: begin
				tableShare = `PPSC_SHARE_FOUR;
				tableOutDiv = output_divide_value >> 2;
			end
		endcase
		if (output_divide_bypass) begin
			tableShare = `PPSC_SHARE_BYPASS;
			tableOutDiv = 11'h001;
		end
	end

	// event decode; the pin is only looked at after two flops
	always_comb begin
		pinEdge = regs_q.syncSafe & ~regs_q.syncPrev;
		pinSync = pinEdge & ~sync_ignore & phase_align_mode_en;
		softSync = phase_align_mode_en & ~regs_q.modePrev;
		alignNow = pinSync | softSync;
		refLast = (ref_divide_value == {REFDIV_W{1'b0}}) ? {REFDIV_W{1'b0}} : ref_divide_value - 1'b1;
		chanLast = (regs_q.outDiv == 11'h000) ? 11'h000 : regs_q.outDiv - 11'h001;
		// one wrap step only: numerator and seed are expected below the denominator
		stepSum = {1'b0, regs_q.acc} + {1'b0, frac_numerator};
		wrapSum = stepSum - {1'b0, frac_denominator};
		// a seed write wraps the same way, so the accumulator never holds the modulus
		seedSum = {1'b0, regs_q.acc} + {1'b0, modulator_seed};
		seedWrap = seedSum - {1'b0, frac_denominator};
	end

	// next-state logic for all block state
	always_comb begin
		regs_d = regs_q;
		regs_d.syncMeta = sync_pin;
		regs_d.syncSafe = regs_q.syncMeta;
		regs_d.syncPrev = regs_q.syncSafe;
		regs_d.modePrev = phase_align_mode_en;
		regs_d.applied = 1'b0;
		regs_d.refTick = 1'b0;
		regs_d.chanTick = 1'b0;

		// share folds into the loop only in sync mode
		if (phase_align_mode_en) begin
			regs_d.share = tableShare;
			regs_d.outDiv = tableOutDiv;
		end else begin
			regs_d.share = `PPSC_SHARE_BYPASS;
			regs_d.outDiv = output_divide_bypass ? 11'h001 : output_divide_value;
		end

		// controller: align lasts one cycle, then armed, or free if the mode has dropped
		case (regs_q.state)
			PPSC_FREE: begin
				if (phase_align_mode_en) begin
					regs_d.state = PPSC_ALIGN;
				end
			end
			PPSC_ARMED: begin
				if (!phase_align_mode_en) begin
					regs_d.state = PPSC_FREE;
				end else if (alignNow) begin
					regs_d.state = PPSC_ALIGN;
				end
			end
			PPSC_ALIGN: begin
				regs_d.state = phase_align_mode_en ? PPSC_ARMED : PPSC_FREE;
			end
			default: begin
				regs_d.state = PPSC_FREE;
			end
		endcase
		// mode flag kept in a flop so the output needs no decode
		regs_d.active = (regs_d.state != PPSC_FREE);

		// out-of-loop dividers restart on the chosen reference edge;
		// in-loop dividers are left to the loop itself
		if (alignNow) begin
			regs_d.refCnt = {REFDIV_W{1'b0}};
			regs_d.chanCnt = `PPSC_RST_COUNT;
			regs_d.applied = 1'b1;
		end else begin
			if (regs_q.refCnt >= refLast) begin
				regs_d.refCnt = {REFDIV_W{1'b0}};
				regs_d.refTick = 1'b1;
			end else begin
				regs_d.refCnt = regs_q.refCnt + 1'b1;
			end
			if (regs_q.chanCnt >= chanLast) begin
				regs_d.chanCnt = `PPSC_RST_COUNT;
				regs_d.chanTick = 1'b1;
			end else begin
				regs_d.chanCnt = regs_q.chanCnt + 11'h001;
			end
		end

		// fractional accumulator: load beats add beats step
		regs_d.carry = 1'b0;
		if (!modulator_reset_n || pinSync) begin
			regs_d.acc = modulator_seed;
		end else if (seed_write && (seedSum >= {1'b0, frac_denominator})) begin
			regs_d.acc = seedWrap[ACC_W-1:0];
		end else if (seed_write) begin
			regs_d.acc = seedSum[ACC_W-1:0];
		end else if (stepSum >= {1'b0, frac_denominator}) begin
			regs_d.acc = wrapSum[ACC_W-1:0];
			regs_d.carry = 1'b1;
		end else begin
			regs_d.acc = stepSum[ACC_W-1:0];
		end

		// phase delay as a ratio, left for software to scale
		regs_d.delayNum = (ACC_W+3)'(modulator_seed) * (ACC_W+3)'(regs_q.share);
		regs_d.delayDen = (ACC_W+11)'(frac_denominator) * (ACC_W+11)'(output_divide_value);
	end

	// single register stage for all state
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regs_q.state <= PPSC_FREE;
			regs_q.syncMeta <= 1'b0;
			regs_q.syncSafe <= 1'b0;
			regs_q.syncPrev <= 1'b0;
			regs_q.modePrev <= 1'b0;
			regs_q.share <= `PPSC_RST_SHARE;
			regs_q.outDiv <= 11'h001;
			regs_q.acc <= {ACC_W{1'b0}};
			regs_q.carry <= 1'b0;
			regs_q.refCnt <= {REFDIV_W{1'b0}};
			regs_q.chanCnt <= `PPSC_RST_COUNT;
			regs_q.refTick <= 1'b0;
			regs_q.chanTick <= 1'b0;
			regs_q.applied <= 1'b0;
			regs_q.active <= 1'b0;
			regs_q.delayNum <= '0;
			regs_q.delayDen <= '0;
		end else begin
			regs_q <= regs_d;
		end
	end

	// outputs straight from the state register
	assign in_loop_divide_share = regs_q.share;
	assign outLoopDivide = regs_q.outDiv;
	assign fracAccum = regs_q.acc;
	assign fracCarry = regs_q.carry;
	assign refDivTick = regs_q.refTick;
	assign chanDivTick = regs_q.chanTick;
	assign syncApplied = regs_q.applied;
	assign syncModeActive = regs_q.active;
	assign phaseDelayNum = regs_q.delayNum;
	assign phaseDelayDen = regs_q.delayDen;

endmodule : ppsc_phase_sync
`default_nettype wire

// >>> ppsc_phase_sync_properties.sv
`default_nettype none
module ppsc_phase_sync_chk
	import ppsc_pkg::*;
#(parameter int ACC_W = 32) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic phase_align_mode_en,
	input wire logic sync_ignore,
	input wire logic sync_pin,
	input wire logic modulator_reset_n,
	input wire logic [ACC_W-1:0] modulator_seed,
	input wire logic seed_write,
	input wire logic [ACC_W-1:0] frac_numerator,
	input wire logic [ACC_W-1:0] frac_denominator,
	input wire logic [10:0] output_divide_value,
	input wire logic output_divide_bypass,
	input wire logic [2:0] in_loop_divide_share,
	input wire logic [ACC_W-1:0] fracAccum,
	input wire logic syncApplied,
	input wire logic [ACC_W+2:0] phaseDelayNum,
	input wire logic [ACC_W+10:0] phaseDelayDen
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// share needs the mode held for a cycle before it settles
	sequence modeOn; phase_align_mode_en [*2]; endsequence
	// pin path must stay open through the resync delay
	sequence pinSeen; $rose(sync_pin) ##0 (!sync_ignore && phase_align_mode_en) [*3]; endsequence
	chk_share_off: assert property (!phase_align_mode_en [*2] |=> in_loop_divide_share == 3'h1)
		else $error("share off");
	chk_share_six: assert property (modeOn ##0 (!output_divide_bypass && output_divide_value == 11'h300)
		|=> in_loop_divide_share == 3'h6) else $error("share six");
	chk_soft_sync: assert property ($rose(phase_align_mode_en) |=> syncApplied) else $error("soft sync");
	chk_pin_sync: assert property (pinSeen |=> syncApplied && fracAccum == $past(modulator_seed))
		else $error("pin sync");
	chk_pin_ignored: assert property ((sync_ignore && $stable(phase_align_mode_en)) [*6] |-> !syncApplied)
		else $error("pin ignored");
	chk_seed_load: assert property (!modulator_reset_n |=> fracAccum == $past(modulator_seed))
		else $error("seed load");
	chk_seed_add: assert property (seed_write && modulator_reset_n && frac_numerator == '0
		|=> fracAccum == ($past(fracAccum) + $past(modulator_seed)) % $past(frac_denominator)) else $error("seed add");
	chk_delay_terms: assert property ($stable(in_loop_divide_share) |=> phaseDelayNum == $past(modulator_seed)
		* $past(in_loop_divide_share) && phaseDelayDen == $past(frac_denominator) * $past(output_divide_value))
		else $error("delay terms");
endmodule : ppsc_phase_sync_chk
bind ppsc_phase_sync ppsc_phase_sync_chk #(.ACC_W(ACC_W)) chk (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.phase_align_mode_en(phase_align_mode_en),
	.sync_ignore(sync_ignore),
	.sync_pin(sync_pin),
	.modulator_reset_n(modulator_reset_n),
	.modulator_seed(modulator_seed),
	.seed_write(seed_write),
	.frac_numerator(frac_numerator),
	.frac_denominator(frac_denominator),
	.output_divide_value(output_divide_value),
	.output_divide_bypass(output_divide_bypass),
	.in_loop_divide_share(in_loop_divide_share),
	.fracAccum(fracAccum),
	.syncApplied(syncApplied),
	.phaseDelayNum(phaseDelayNum),
	.phaseDelayDen(phaseDelayDen)
);
`default_nettype wire

// >>> ppsc_sync_src.sv
`default_nettype none
module ppsc_sync_src (
	input wire logic ref_clk,
	input wire logic fire,
	output logic sync_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// launched just after a rising edge so no edge is ambiguous; always driven, never floating
	initial sync_pin = 1'b0;
	always @(posedge ref_clk) sync_pin <= fire;
endmodule : ppsc_sync_src
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, sys_rst = 1'b1, phase_align_mode_en = 1'b0, sync_ignore = 1'b0, fire = 1'b0;
	logic seed_write = 1'b0, modulator_reset_n = 1'b1, output_divide_bypass = 1'b0, sync_pin, fracCarry;
	logic refDivTick, chanDivTick, syncApplied, syncModeActive;
	// denominator equals the share (k = 1); unit seed steps trade faint spurs for resolution
	logic [31:0] modulator_seed = 32'h1, frac_numerator = 32'h0, frac_denominator = 32'h4, fracAccum;
	logic [10:0] output_divide_value = 11'h018, outLoopDivide;
	logic [10:0] sixes [7] = '{11'h006, 11'h00C, 11'h030, 11'h048, 11'h060, 11'h180, 11'h300};
	logic [7:0] ref_divide_value = 8'h03;
	logic [2:0] in_loop_divide_share;
	logic [34:0] phaseDelayNum;
	logic [42:0] phaseDelayDen;
	int fails = 0, cmp_count = 0, hits, hitAt, refAt, chanAt;
	ppsc_phase_sync dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.phase_align_mode_en(phase_align_mode_en),
		.sync_ignore(sync_ignore),
		.sync_pin(sync_pin),
		.modulator_reset_n(modulator_reset_n),
		.modulator_seed(modulator_seed),
		.seed_write(seed_write),
		.frac_numerator(frac_numerator),
		.frac_denominator(frac_denominator),
		.output_divide_value(output_divide_value),
		.output_divide_bypass(output_divide_bypass),
		.ref_divide_value(ref_divide_value),
		.in_loop_divide_share(in_loop_divide_share),
		.outLoopDivide(outLoopDivide),
		.fracAccum(fracAccum),
		.fracCarry(fracCarry),
		.refDivTick(refDivTick),
		.chanDivTick(chanDivTick),
		.syncApplied(syncApplied),
		.syncModeActive(syncModeActive),
		.phaseDelayNum(phaseDelayNum),
		.phaseDelayDen(phaseDelayDen)
	);
	ppsc_sync_src src (
		.ref_clk(ref_clk),
		.fire(fire),
		.sync_pin(sync_pin)
	);
	// tb inputs move on the falling edge; sync_pin follows fire on the rising edge
	always #50 ref_clk = ~ref_clk;
	task step(input int n); repeat (n) @(negedge ref_clk); endtask : step
	task chk(input logic [42:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	// fixed window, so a lost pulse shows as a count and never hangs
	// also notes how many cycles after the sync each divider first wraps
	task watch(input int n);
		hits = 0;
		hitAt = 0;
		refAt = 0;
		chanAt = 0;
		for (int i = 1; i <= n; i++) begin
			step(1);
			if (syncApplied === 1'b1) begin
				hits++;
				hitAt = i;
			end
			if (hits > 0 && refAt == 0 && refDivTick === 1'b1) refAt = i - hitAt;
			if (hits > 0 && chanAt == 0 && chanDivTick === 1'b1) chanAt = i - hitAt;
		end
	endtask : watch
	task pin_sync(input int exp);
		fire = 1'b1;
		step(1);
		fire = 1'b0;
		watch(10);
		chk(hits, exp);
	endtask : pin_sync
	task seed_add(input logic [31:0] exp);
		seed_write = 1'b1;
		step(1);
		seed_write = 1'b0;
		chk(fracAccum, exp);
		step(1);
	endtask : seed_add
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		step(12);
		sys_rst = 1'b0;
		chk(in_loop_divide_share, 3'h1);
		step(2);
		phase_align_mode_en = 1'b1;
		watch(4);
		chk(hits, 1);
		chk(outLoopDivide, 11'h006);
		chk(syncModeActive, 1'b1);
		foreach (sixes[i]) begin
			output_divide_value = sixes[i];
			step(3);
			chk(in_loop_divide_share, 3'h6);
		end
		output_divide_bypass = 1'b1;
		step(3);
		chk(in_loop_divide_share, 3'h1);
		output_divide_bypass = 1'b0;
		output_divide_value = 11'h018;
		modulator_reset_n = 1'b0;
		step(3);
		modulator_reset_n = 1'b1;
		chk(fracAccum, 32'h1);
		chk(phaseDelayNum, 35'h4);
		chk(phaseDelayDen, 43'h60);
		for (int k = 2; k < 7; k++) seed_add(32'(k % 4));
		pin_sync(1);
		chk(fracAccum, 32'h1);
		chk(refAt, 3);
		chk(chanAt, 6);
		sync_ignore = 1'b1;
		pin_sync(0);
		sync_ignore = 1'b0;
		phase_align_mode_en = 1'b0;
		pin_sync(0);
		chk(syncModeActive, 1'b0);
		chk(in_loop_divide_share, 3'h1);
		chk(outLoopDivide, 11'h018);
		// a non-zero step wraps at the denominator and pulses the carry once
		frac_numerator = 32'h3;
		step(1);
		chk({fracCarry, fracAccum}, {1'b1, 32'h0});
		step(1);
		chk({fracCarry, fracAccum}, {1'b0, 32'h3});
		give_verdict();
	end
endmodule : tb
`default_nettype wire
